// ===== design/rsc_pkg.sv
// package: constants and carriers for reset and standby control
//
// Overview of operation
// - reset from pin low or enabled watchdog overflow
// - both resets same; main oscillator off, subsystem runs
// - during reset program counter loads reset vector
// - hold cpu idle two-to-sixteen main clocks
// - halt instruction enters halt, stop enters stop
// - stop only accepted while on main clock
// - stop gates cpu and main osc; halt cpu only
// - standby: cpu idle, port outputs frozen
// - halt wakes on interrupt, nmi, test, reset
// - stop exit waits selected settling time first
package rsc_pkg;
	localparam int          RSC_SETTLE_RESET_LOG2 = 16;
	localparam logic [15:0] RSC_VEC_ADDR_LO      = 16'h0000;
	localparam logic [15:0] RSC_VEC_ADDR_HI      = 16'h0001;
	localparam int          RSC_SEL_W            = 3;
	localparam int          RSC_CNT_W            = 20;
	// stop-exit settling counts, five selectable choices
	localparam logic [RSC_CNT_W-1:0] RSC_STOP_WAIT0 = 20'h0_1000;
	localparam logic [RSC_CNT_W-1:0] RSC_STOP_WAIT1 = 20'h0_4000;
	localparam logic [RSC_CNT_W-1:0] RSC_STOP_WAIT2 = 20'h1_0000;
	localparam logic [RSC_CNT_W-1:0] RSC_STOP_WAIT3 = 20'h2_0000;
	localparam logic [RSC_CNT_W-1:0] RSC_STOP_WAIT4 = 20'h4_0000;

	typedef enum logic [1:0] {
		RSC_INSN_NONE,
		RSC_INSN_HALT,
		RSC_INSN_STOP
	} rsc_insn_t;

	// wake sources for standby release
	typedef struct packed {
		logic irq_unmasked;
		logic nmi;
		logic test_unmasked;
	} rsc_wake_t;

	// clock gate outputs
	typedef struct packed {
		logic main_osc_en;
		logic sub_osc_en;
		logic cpu_clk_en;
	} rsc_clk_t;
endpackage

// ===== design/rsc_top.sv
// top: reset sequencing and standby control
`timescale 1ns/1ps
`default_nettype none
module rsc_top #(
	parameter int SETTLE_RESET_CYCLES = 2 ** rsc_pkg::RSC_SETTLE_RESET_LOG2
) (
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_in,
	input  wire logic                      reset_pin_n_in,
	input  wire logic                      wdt_overflow_in,
	input  wire logic                      wdt_reset_en_in,
	input  wire rsc_pkg::rsc_insn_t        insn_in,
	input  wire logic                      cpu_on_main_clk_in,
	input  wire rsc_pkg::rsc_wake_t        wake_in,
	input  wire logic [rsc_pkg::RSC_SEL_W-1:0] osc_settle_select_in,
	input  wire logic [7:0]                mem_data_in,
	input  wire logic [7:0]                port_data_in,
	output logic      [15:0]               mem_addr_out,
	output logic                           mem_rd_out,
	output logic      [15:0]               pc_out,
	output logic                           pc_load_out,
	output logic                           cpu_run_out,
	output rsc_pkg::rsc_clk_t              clk_out,
	output logic      [7:0]                port_out,
	output logic                           in_reset_out
);
	typedef enum logic [2:0] {
		ST_RESET, ST_SETTLE, ST_RUN, ST_HALT, ST_STOP, ST_STOP_WAIT
	} rsc_state_t;

	rsc_state_t state_reg;
	rsc_state_t state_next;
	logic [1:0] pin_sync_reg;
	logic [rsc_pkg::RSC_CNT_W-1:0] cnt_reg;
	logic [rsc_pkg::RSC_SEL_W-1:0] sel_reg;
	logic [7:0] port_reg;
	logic [15:0] pc_reg;
	logic        pc_load_reg;
	logic [15:0] vec;
	logic        vec_done;
	logic [rsc_pkg::RSC_CNT_W-1:0] dwell_reg;
	logic        main_osc_on;
	logic        cpu_clk_on;

	// settling counts
	localparam logic [rsc_pkg::RSC_CNT_W-1:0] SETTLE_CNT = SETTLE_RESET_CYCLES[rsc_pkg::RSC_CNT_W-1:0];

	function automatic logic [rsc_pkg::RSC_CNT_W-1:0] stop_wait(input logic [rsc_pkg::RSC_SEL_W-1:0] s);
		case (s)
			3'h0: stop_wait = rsc_pkg::RSC_STOP_WAIT0;
			3'h1: stop_wait = rsc_pkg::RSC_STOP_WAIT1;
			3'h2: stop_wait = rsc_pkg::RSC_STOP_WAIT2;
			3'h3: stop_wait = rsc_pkg::RSC_STOP_WAIT3;
			default: stop_wait = rsc_pkg::RSC_STOP_WAIT4;
		endcase
	endfunction

	wire pin_reset  = !pin_sync_reg[1];
	wire wdt_reset  = wdt_overflow_in && wdt_reset_en_in;
	// both sources take the same path
	wire any_reset  = pin_reset || wdt_reset;
	wire wake_any   = wake_in.irq_unmasked || wake_in.nmi || wake_in.test_unmasked;
	wire cnt_done   = (cnt_reg == '0);
	// stop refused unless on main clock
	wire stop_ok    = (insn_in == rsc_pkg::RSC_INSN_STOP) && cpu_on_main_clk_in;

	rsc_vector_fetch u_vec (
		.ref_clk_in   (ref_clk_in),
		.rst_in       (rst_in),
		.start_in     (state_reg == ST_RESET),
		.mem_data_in  (mem_data_in),
		.mem_addr_out (mem_addr_out),
		.mem_rd_out   (mem_rd_out),
		.vector_out   (vec),
		.done_out     (vec_done)
	);

	// next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET:  state_next = (!any_reset && vec_done) ? ST_SETTLE : ST_RESET;
			// hold idle until reset settle count done
			ST_SETTLE: state_next = cnt_done ? ST_RUN : ST_SETTLE;
			ST_RUN: begin
				if (insn_in == rsc_pkg::RSC_INSN_HALT)
					state_next = ST_HALT;
				else if (stop_ok)
					state_next = ST_STOP;
			end
			ST_HALT:   state_next = wake_any ? ST_RUN : ST_HALT;
			// stop exit goes through settling wait
			ST_STOP:   state_next = wake_any ? ST_STOP_WAIT : ST_STOP;
			ST_STOP_WAIT: state_next = cnt_done ? ST_RUN : ST_STOP_WAIT;
			default:   state_next = ST_RESET;
		endcase
		if (any_reset)
			state_next = ST_RESET;
	end

	// state, counter, latched selection
	always_ff @(posedge ref_clk_in) begin
		pin_sync_reg <= rst_in ? 2'h3 : {pin_sync_reg[0], reset_pin_n_in};
		if (rst_in) begin
			state_reg <= ST_RESET;
			cnt_reg   <= '0;
			sel_reg   <= '0;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_RESET)
				cnt_reg <= SETTLE_CNT - 1'b1;
			else if (state_reg == ST_STOP)
				cnt_reg <= stop_wait(sel_reg) - 1'b1;
			else if (!cnt_done)
				cnt_reg <= cnt_reg - 1'b1;
			if (state_reg == ST_RUN)
				sel_reg <= osc_settle_select_in;
		end
	end

	// program counter and frozen port latch
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pc_reg      <= 16'h0000;
			pc_load_reg <= 1'b0;
			port_reg    <= 8'h00;
		end else begin
			// pc takes vector while in reset
			pc_load_reg <= (state_reg == ST_RESET) && vec_done;
			if ((state_reg == ST_RESET) && vec_done)
				pc_reg <= vec;
			if (state_reg == ST_RUN)
				port_reg <= port_data_in;
		end
	end

	// cycles spent in the current state, a checking aid for the settle times;
	// kept apart from cnt_reg so a slip in the count loader cannot hide itself
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || (state_next != state_reg))
			dwell_reg <= '0;
		else if (dwell_reg != '1)
			dwell_reg <= dwell_reg + 1'b1;
	end

	// clock gating per mode
	// main oscillator restarts in the stop wait so it can settle before run
	assign main_osc_on = !(state_reg == ST_RESET || state_reg == ST_STOP);
	assign cpu_clk_on  = (state_reg == ST_RUN);
	assign clk_out     = '{main_osc_en: main_osc_on, sub_osc_en: 1'b1, cpu_clk_en: cpu_clk_on};
	assign cpu_run_out  = (state_reg == ST_RUN);
	assign port_out     = port_reg;
	assign pc_out       = pc_reg;
	assign pc_load_out  = pc_load_reg;
	assign in_reset_out = (state_reg == ST_RESET);

	// assertions, grouped by rule; mode change antecedents other than stop_wait_a leave out a reset in the
	// same cycle because a reset source always wins over the mode change checked

	sequence halt_entry_s;
		state_reg == ST_RUN && insn_in == rsc_pkg::RSC_INSN_HALT && !any_reset;
	endsequence
	sequence stop_entry_s;
		state_reg == ST_RUN && stop_ok && !any_reset;
	endsequence
	halt_entry_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		halt_entry_s |=> state_reg == ST_HALT) else $error("halt not entered");
	stop_entry_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		stop_entry_s |=> state_reg == ST_STOP) else $error("stop not entered");

	// stop on the subclock is ignored
	stop_guard_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_reg == ST_RUN && !cpu_on_main_clk_in && insn_in == rsc_pkg::RSC_INSN_STOP
		 && !any_reset) |=> state_reg != ST_STOP) else $error("stop off main clock");

	reset_osc_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		in_reset_out |-> !clk_out.main_osc_en && clk_out.sub_osc_en) else $error("osc in reset");
	wdt_reset_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(wdt_overflow_in && wdt_reset_en_in) |=> in_reset_out) else $error("wdt reset missed");
	pin_reset_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		pin_reset |=> in_reset_out) else $error("pin reset missed");
	wdt_masked_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_reg == ST_RUN && wdt_overflow_in && !wdt_reset_en_in && !pin_reset
		 && insn_in == rsc_pkg::RSC_INSN_NONE) |=> cpu_run_out) else $error("masked wdt reset");

	standby_idle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_reg == ST_HALT || state_reg == ST_STOP) |-> !cpu_run_out ##1 $stable(port_out))
		else $error("port moved");
	halt_clk_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_reg == ST_HALT) |-> clk_out.main_osc_en && !clk_out.cpu_clk_en) else $error("halt clk");
	stop_clk_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_reg == ST_STOP) |-> !clk_out.main_osc_en && clk_out.sub_osc_en
		&& !clk_out.cpu_clk_en) else $error("stop clk");

	// wake paths; the stop wait length is checked against the dwell counter
	sequence stop_wake_s;
		state_reg == ST_STOP && wake_any && !any_reset;
	endsequence
	sequence wait_end_s;
		state_reg == ST_STOP_WAIT && cnt_done && !any_reset;
	endsequence
	halt_wake_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_reg == ST_HALT && wake_any && !any_reset) |=> cpu_run_out) else $error("no wake");
	stop_wait_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_reg == ST_STOP && wake_any) |=> !cpu_run_out[*2]) else $error("stop exit early");
	stop_wake_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		stop_wake_s |=> state_reg == ST_STOP_WAIT && clk_out.main_osc_en) else $error("stop wake");
	stop_wait_len_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		wait_end_s |-> dwell_reg == stop_wait(sel_reg) - 1'b1)
		else $error("stop wait length");

	// vector load and reset settle time
	sequence settle_end_s;
		state_reg == ST_SETTLE && cnt_done && !any_reset;
	endsequence
	reset_settle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(in_reset_out) |-> !cpu_run_out[*8]) else $error("settle too short");
	settle_len_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		settle_end_s |-> dwell_reg == SETTLE_CNT - 1'b1) else $error("settle length");
	pc_load_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		pc_load_out |-> pc_out == vec) else $error("pc not vector");
endmodule
`default_nettype wire

// ===== design/rsc_vector_fetch.sv
// vector fetch: reads two vector bytes and assembles the start address
`timescale 1ns/1ps
`default_nettype none
module rsc_vector_fetch (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic        start_in,
	input  wire logic [7:0]  mem_data_in,
	output logic      [15:0] mem_addr_out,
	output logic             mem_rd_out,
	output logic      [15:0] vector_out,
	output logic             done_out
);
	logic [1:0] step_reg;
	logic [7:0] low_reg;
	logic [15:0] vec_reg;

	// read address follows the step; low byte first
	assign mem_addr_out = step_reg[0] ? rsc_pkg::RSC_VEC_ADDR_HI : rsc_pkg::RSC_VEC_ADDR_LO;
	assign mem_rd_out   = start_in && (step_reg != 2'h3);
	assign done_out     = (step_reg == 2'h3);
	assign vector_out   = vec_reg;

	// memory answers one cycle after the read
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || !start_in) begin
			step_reg <= 2'h0;
			low_reg  <= 8'h00;
			vec_reg  <= 16'h0000;
		end else begin
			if (step_reg != 2'h3)
				step_reg <= step_reg + 2'h1;
			if (step_reg == 2'h1)
				low_reg <= mem_data_in;
			if (step_reg == 2'h2)
				vec_reg <= {mem_data_in, low_reg};
		end
	end
endmodule
`default_nettype wire

// ===== dv/rsc_mem_model.sv
// behavioural boot memory that answers vector byte reads
`timescale 1ns/1ps
`default_nettype none
module rsc_mem_model #(
	parameter logic [7:0] LO_BYTE = 8'h34,
	parameter logic [7:0] HI_BYTE = 8'h12
) (
	input  wire logic        clk_in,
	input  wire logic        rd_in,
	input  wire logic [15:0] addr_in,
	output logic      [7:0]  data_out
);
	// low byte first
	// idle bus inverts every cycle, so a stale byte shows again only on alternate idle cycles
	always_ff @(posedge clk_in) begin
		data_out <= !rd_in ? ~data_out : (addr_in == 16'h0000) ? LO_BYTE :
			(addr_in == 16'h0001) ? HI_BYTE : 8'hff;
	end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// testbench for reset and standby control
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {rsc_pkg::rsc_insn_t i; logic m; logic r; logic [2:0] c;
		logic [2:0] s; int w;} rsc_row_t;
	logic ref_clk_in, rst_in, reset_pin_n_in, wdt_overflow_in, wdt_reset_en_in, cpu_on_main_clk_in;
	rsc_pkg::rsc_insn_t insn_in;
	rsc_pkg::rsc_wake_t wake_in;
	logic [2:0] osc_settle_select_in;
	logic [7:0] mem_data_in, port_data_in, port_out;
	logic [15:0] mem_addr_out, pc_out;
	logic mem_rd_out, pc_load_out, cpu_run_out, in_reset_out;
	rsc_pkg::rsc_clk_t clk_out;
	int n_errors, tests_run, cyc, k;
	// halt either clock, stop on main, stop on subclock refused, stop with longer wait
	rsc_row_t rows [5] = '{'{rsc_pkg::RSC_INSN_HALT, 1, 0, 3'h6, 3'h0, 1},
		'{rsc_pkg::RSC_INSN_HALT, 0, 0, 3'h6, 3'h0, 1},
		'{rsc_pkg::RSC_INSN_STOP, 1, 0, 3'h2, 3'h0, int'(rsc_pkg::RSC_STOP_WAIT0) + 1},
		'{rsc_pkg::RSC_INSN_STOP, 0, 1, 3'h7, 3'h0, 0},
		'{rsc_pkg::RSC_INSN_STOP, 1, 0, 3'h2, 3'h1, int'(rsc_pkg::RSC_STOP_WAIT1) + 1}};
	rsc_top #(.SETTLE_RESET_CYCLES(16)) dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.reset_pin_n_in(reset_pin_n_in), .wdt_overflow_in(wdt_overflow_in),
		.wdt_reset_en_in(wdt_reset_en_in), .insn_in(insn_in),
		.cpu_on_main_clk_in(cpu_on_main_clk_in), .wake_in(wake_in),
		.osc_settle_select_in(osc_settle_select_in), .mem_data_in(mem_data_in),
		.port_data_in(port_data_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
		.pc_out(pc_out), .pc_load_out(pc_load_out), .cpu_run_out(cpu_run_out),
		.clk_out(clk_out), .port_out(port_out), .in_reset_out(in_reset_out));
	rsc_mem_model mem_u (.clk_in(ref_clk_in), .rd_in(mem_rd_out), .addr_in(mem_addr_out),
		.data_out(mem_data_in));
	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask
	// wait for run under a bound, then compare the vector and the wake time
	task automatic wait_run(input int n, input int e);
		int i;
		for (i = 0; i < n && cpu_run_out !== 1'b1; i++) @(negedge ref_clk_in);
		chk(16'(cpu_run_out), 16'h0001);
		chk(pc_out, 16'h1234);
		if (e >= 0)
			chk(16'(i), 16'(e));
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard, generous against the longest stop wait the rows select
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		{rst_in, reset_pin_n_in, wdt_overflow_in, wdt_reset_en_in} = 4'hc;
		insn_in = rsc_pkg::RSC_INSN_NONE;
		{cpu_on_main_clk_in, wake_in} = 4'h0;
		osc_settle_select_in = 3'h0;
		port_data_in = 8'ha5;
		repeat (3) @(negedge ref_clk_in);
		chk(16'({in_reset_out, cpu_run_out, clk_out}), 16'h0012);
		rst_in = 1'b0;
		k = 0;
		while (cpu_run_out !== 1'b1 && k < 100) begin
			@(negedge ref_clk_in);
			k++;
			if (k == 1)
				chk(mem_addr_out, 16'h0001);
			if (k == 4)
				chk(16'({pc_load_out, mem_rd_out}), 16'h0002);
		end
		chk(16'(k >= 16), 16'h0001);
		chk(16'(k), 16'h0014);
		wait_run(1, 0);
		$display("reset test done");
		foreach (rows[j]) begin
			cpu_on_main_clk_in = rows[j].m;
			osc_settle_select_in = rows[j].s;
			port_data_in = 8'ha5;
			@(negedge ref_clk_in);
			insn_in = rows[j].i;
			@(negedge ref_clk_in);
			insn_in = rsc_pkg::RSC_INSN_NONE;
			port_data_in = 8'h5a;
			repeat (2) @(negedge ref_clk_in);
			chk(16'(cpu_run_out), 16'(rows[j].r));
			chk(16'(clk_out), 16'(rows[j].c));
			chk(16'(port_out), 16'(rows[j].r ? 8'h5a : 8'ha5));
			wake_in = 3'h4;
			wait_run(20000, rows[j].w);
			wake_in = 3'h0;
			$display("standby row %0d done", j);
		end
		// disabled watchdog overflow must not reset
		wdt_overflow_in = 1'b1;
		repeat (3) @(negedge ref_clk_in);
		chk(16'(in_reset_out), 16'h0000);
		wdt_reset_en_in = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		chk(16'({in_reset_out, clk_out}), 16'h000a);
		{wdt_overflow_in, wdt_reset_en_in} = 2'h0;
		wait_run(100, -1);
		reset_pin_n_in = 1'b0;
		repeat (4) @(negedge ref_clk_in);
		chk(16'({in_reset_out, clk_out}), 16'h000a);
		reset_pin_n_in = 1'b1;
		wait_run(100, -1);
		$display("reset source test done");
		finish_test();
	end
endmodule
`default_nettype wire
